// >>> common/calu_map.svh
// Constants for the carry-aware arithmetic and logic unit
// How it works
// - Add sources plus carry into destination
// - Word form is unsigned 16 bits
// - Double form is unsigned 32 bits
// - Out-of-range add or subtract sets carry
// - Executes every cycle the enable is high and the operation code is known
// - Subtract second source and carry from first
// - BCD forms do packed decimal digit arithmetic
// - Magnitude negates destination when its top bit is set
// - Negate is inversion plus one
// - Invert flips every destination bit
// - Magnitude, negate, invert work in place
// - AND sets bits where both are one
// - OR sets bits where either is one
// - XOR sets bits where sources differ
`ifndef CALU_MAP_SVH
`define CALU_MAP_SVH

`define CALU_WORD_W 16
`define CALU_DBL_W 32
`define CALU_REGS 16
`define CALU_IDX_W 4
`define CALU_IDX_ONE 4'h1
`define CALU_WORD_RST 16'h0000
`define CALU_CARRY_RST 1'b0
`define CALU_RESULT_RST 32'h00000000
`define CALU_VALID_RST 1'b0
`define CALU_DIGITS 8
`define CALU_WORD_DIGITS 4
`define CALU_BCD_MAX 5'h09
`define CALU_BCD_ADJ_ADD 5'h06
`define CALU_BCD_ADJ_SUB 5'h0a

`define CALU_OP_ADC 4'h0
`define CALU_OP_BCD_ADC 4'h1
`define CALU_OP_SUB_BORROW 4'h2
`define CALU_OP_BCD_SUB_BORROW 4'h3
`define CALU_OP_ABS 4'h4
`define CALU_OP_TWOS 4'h5
`define CALU_OP_NOT 4'h6
`define CALU_OP_AND 4'h7
`define CALU_OP_OR 4'h8
`define CALU_OP_XOR 4'h9

`endif

// >>> common/calu_pkg.sv
// Types shared by the carry-aware arithmetic and logic unit
`include "calu_map.svh"

package calu_pkg;

  // Operation codes presented with each execution request
  typedef enum logic [3:0] {
    calu_op_adc = `CALU_OP_ADC,
    calu_op_bcd_adc = `CALU_OP_BCD_ADC,
    calu_op_sub_borrow = `CALU_OP_SUB_BORROW,
    calu_op_bcd_sub_borrow = `CALU_OP_BCD_SUB_BORROW,
    calu_op_abs = `CALU_OP_ABS,
    calu_op_twos = `CALU_OP_TWOS,
    calu_op_not = `CALU_OP_NOT,
    calu_op_and = `CALU_OP_AND,
    calu_op_or = `CALU_OP_OR,
    calu_op_xor = `CALU_OP_XOR
  } calu_op_t;

endpackage : calu_pkg

// >>> core/calu_core.sv
// Carry-aware arithmetic and logic datapath with its own word register file
`timescale 1ns/1ps
`include "calu_map.svh"

module calu_core (
  input wire logic clock,
  input wire logic rstn,
  input wire logic exec_en,
  input wire calu_pkg::calu_op_t exec_op,
  input wire logic exec_double,
  input wire logic [`CALU_IDX_W-1:0] first_source,
  input wire logic [`CALU_IDX_W-1:0] second_source,
  input wire logic [`CALU_IDX_W-1:0] dest_idx,
  input wire logic host_wr_en,
  input wire logic [`CALU_IDX_W-1:0] host_wr_idx,
  input wire logic [`CALU_WORD_W-1:0] host_wr_data,
  input wire logic carry_wr_en,
  input wire logic carry_wr_data,
  input wire logic [`CALU_IDX_W-1:0] host_rd_idx,
  output logic [`CALU_WORD_W-1:0] host_rd_data,
  output logic carry_flag,
  output logic [`CALU_DBL_W-1:0] result,
  output logic result_valid
);

  // Word register file, double words use the pair idx (low) and idx+1 (high)
  logic [`CALU_WORD_W-1:0] regs_q [`CALU_REGS];
  logic carry_q;
  logic [`CALU_DBL_W-1:0] result_q;
  logic result_valid_q;
  logic [`CALU_WORD_W-1:0] rd_data_q;

  // Operand fetch, high words are zero in word form
  // The high index wraps from the last entry back to entry zero, so a
  // double word that starts in the last entry borrows entry zero as its top
  wire [`CALU_IDX_W-1:0] src_a_hi_idx = first_source + `CALU_IDX_ONE;
  wire [`CALU_IDX_W-1:0] src_b_hi_idx = second_source + `CALU_IDX_ONE;
  wire [`CALU_IDX_W-1:0] d_hi_idx = dest_idx + `CALU_IDX_ONE;
  wire [`CALU_WORD_W-1:0] zero_word = `CALU_WORD_RST;
  wire [`CALU_WORD_W-1:0] opa_hi = exec_double ? regs_q[src_a_hi_idx] : zero_word;
  wire [`CALU_WORD_W-1:0] opb_hi = exec_double ? regs_q[src_b_hi_idx] : zero_word;
  wire [`CALU_WORD_W-1:0] opd_hi = exec_double ? regs_q[d_hi_idx] : zero_word;
  wire [`CALU_DBL_W-1:0] opa = {opa_hi, regs_q[first_source]};
  wire [`CALU_DBL_W-1:0] opb = {opb_hi, regs_q[second_source]};
  wire [`CALU_DBL_W-1:0] opd = {opd_hi, regs_q[dest_idx]};
  wire [`CALU_DBL_W:0] cin_ext = {{`CALU_DBL_W{1'b0}}, carry_q};

  // Operands widened by one bit so the carry or borrow lands in the top bit
  wire [`CALU_DBL_W:0] opa_ext = {1'b0, opa};
  wire [`CALU_DBL_W:0] opb_ext = {1'b0, opb};

  // Binary add and subtract with carry, one spare bit catches the overflow
  // In word form the high halves are zero, so the borrow of a word
  // subtract still shows in the top bit of the wide difference
  wire [`CALU_DBL_W:0] bin_sum = opa_ext + opb_ext + cin_ext;
  wire [`CALU_DBL_W:0] bin_diff = opa_ext - opb_ext - cin_ext;
  wire bin_sum_carry = exec_double ? bin_sum[`CALU_DBL_W] : bin_sum[`CALU_WORD_W];
  wire bin_diff_borrow = bin_diff[`CALU_DBL_W];

  // Packed BCD digit chain, carry and borrow ripple digit to digit
  // Digits above nine give a fixed but meaningless answer; nothing flags
  // them, so the program must keep its operands decimal
  logic [`CALU_DIGITS:0] add_dc;
  logic [`CALU_DIGITS:0] sub_dc;
  logic [`CALU_DBL_W-1:0] bcd_sum;
  logic [`CALU_DBL_W-1:0] bcd_diff;
  assign add_dc[0] = carry_q;
  assign sub_dc[0] = carry_q;

  genvar g;
  generate
    for (g = 0; g < `CALU_DIGITS; g = g + 1) begin : g_digit
      wire [4:0] na = {1'b0, opa[4*g+3:4*g]};
      wire [4:0] nb = {1'b0, opb[4*g+3:4*g]};
      wire [4:0] dsum = na + nb + {4'h0, add_dc[g]};
      wire [4:0] ddiff = na - nb - {4'h0, sub_dc[g]};
      wire sum_over = dsum > `CALU_BCD_MAX;
      wire diff_under = ddiff[4]; // Digit went below zero
      wire [4:0] sum_adj = dsum + `CALU_BCD_ADJ_ADD;
      // Adding ten modulo 32 brings a wrapped digit back into zero to nine
      wire [4:0] diff_adj = ddiff + `CALU_BCD_ADJ_SUB;
      // Decimal adjust of each digit
      assign bcd_sum[4*g+3:4*g] = sum_over ? sum_adj[3:0] : dsum[3:0];
      assign bcd_diff[4*g+3:4*g] = diff_under ? diff_adj[3:0] : ddiff[3:0];
      // Carry and borrow out of this digit feed the next one
      assign add_dc[g+1] = sum_over;
      assign sub_dc[g+1] = diff_under;
    end
  endgenerate

  // Decimal carry taken from the last digit of the chosen width
  wire bcd_sum_carry = exec_double ? add_dc[`CALU_DIGITS] : add_dc[`CALU_WORD_DIGITS];
  wire bcd_diff_borrow = exec_double ? sub_dc[`CALU_DIGITS] : sub_dc[`CALU_WORD_DIGITS];

  // In-place unary forms on the destination value
  // In word form the inverted high half is all ones; the width mask below
  // clears it before the value reaches the result or the register file
  wire [`CALU_DBL_W-1:0] one_dbl = {{(`CALU_DBL_W-1){1'b0}}, 1'b1};
  wire [`CALU_DBL_W-1:0] inv_val = ~opd;
  wire [`CALU_DBL_W-1:0] twos_val = inv_val + one_dbl;
  // Sign taken from the top bit of the chosen width
  wire top_bit = exec_double ? opd[`CALU_DBL_W-1] : opd[`CALU_WORD_W-1];
  // The most negative value has no positive twin and comes back unchanged
  wire [`CALU_DBL_W-1:0] abs_val = top_bit ? twos_val : opd;

  // Bitwise forms
  wire [`CALU_DBL_W-1:0] and_val = opa & opb;
  wire [`CALU_DBL_W-1:0] or_val = opa | opb;
  wire [`CALU_DBL_W-1:0] xor_val = opa ^ opb;

  // Operation select
  wire is_adc = exec_op == calu_pkg::calu_op_adc;
  wire is_bcd_adc = exec_op == calu_pkg::calu_op_bcd_adc;
  wire is_sub_borrow = exec_op == calu_pkg::calu_op_sub_borrow;
  wire is_bcd_sub_borrow = exec_op == calu_pkg::calu_op_bcd_sub_borrow;
  wire is_abs = exec_op == calu_pkg::calu_op_abs;
  wire is_twos = exec_op == calu_pkg::calu_op_twos;
  wire is_not = exec_op == calu_pkg::calu_op_not;
  wire is_and = exec_op == calu_pkg::calu_op_and;
  wire is_or = exec_op == calu_pkg::calu_op_or;
  wire is_xor = exec_op == calu_pkg::calu_op_xor;
  wire is_carry_op = is_adc | is_bcd_adc | is_sub_borrow | is_bcd_sub_borrow;
  wire is_unary_op = is_abs | is_twos | is_not;
  wire is_logic_op = is_and | is_or | is_xor;
  // Codes outside the table are refused: nothing is written, no valid
  wire op_known = is_carry_op | is_unary_op | is_logic_op;

  // Result before the width mask
  wire [`CALU_DBL_W-1:0] raw_val =
    is_adc ? bin_sum[`CALU_DBL_W-1:0] :
    is_bcd_adc ? bcd_sum :
    is_sub_borrow ? bin_diff[`CALU_DBL_W-1:0] :
    is_bcd_sub_borrow ? bcd_diff :
    is_abs ? abs_val :
    is_twos ? twos_val :
    is_not ? inv_val :
    is_and ? and_val :
    is_or ? or_val :
    xor_val;

  // Word form keeps only the low 16 bits
  wire [`CALU_DBL_W-1:0] width_mask = exec_double ? {`CALU_DBL_W{1'b1}} :
                                      {{`CALU_WORD_W{1'b0}}, {`CALU_WORD_W{1'b1}}};
  wire [`CALU_DBL_W-1:0] exec_val = raw_val & width_mask;

  // Carry outcome, set when out of range and cleared when in range
  // A borrow out of a subtract counts as leaving the range
  wire carry_next =
    is_adc ? bin_sum_carry :
    is_bcd_adc ? bcd_sum_carry :
    is_sub_borrow ? bin_diff_borrow :
    bcd_diff_borrow;

  // A request with a known code is honoured on every cycle the enable is high
  wire exec_fire = exec_en & op_known;
  // Logic and unary forms leave the carry alone
  wire carry_upd = exec_fire & is_carry_op;

  // Register file entries, execution writes win over host writes
  // A host write lost to an execution in the same cycle is not retried
  generate
    for (g = 0; g < `CALU_REGS; g = g + 1) begin : g_entry
      // Index of this entry as a register file address
      localparam int entry_num = g;
      wire [`CALU_IDX_W-1:0] entry_idx = entry_num[`CALU_IDX_W-1:0];
      wire lo_hit = exec_fire && (dest_idx == entry_idx);
      wire hi_hit = exec_fire && exec_double && (d_hi_idx == entry_idx);
      wire host_hit = host_wr_en && (host_wr_idx == entry_idx);
      wire [`CALU_WORD_W-1:0] entry_d =
        lo_hit ? exec_val[`CALU_WORD_W-1:0] :
        hi_hit ? exec_val[`CALU_DBL_W-1:`CALU_WORD_W] :
        host_hit ? host_wr_data :
        regs_q[g];
      // Storage for one word
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          regs_q[g] <= `CALU_WORD_RST;
        end else begin
          regs_q[g] <= entry_d;
        end
      end
    end
  endgenerate

  // Carry flag, the datapath outcome wins over a host write
  wire carry_d = carry_upd ? carry_next :
                 carry_wr_en ? carry_wr_data :
                 carry_q;

  // Result holds its last value until the next execution
  wire [`CALU_DBL_W-1:0] result_d = exec_fire ? exec_val : result_q;

  // Carry flag register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      carry_q <= `CALU_CARRY_RST;
    end else begin
      carry_q <= carry_d;
    end
  end

  // Result register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      result_q <= `CALU_RESULT_RST;
    end else begin
      result_q <= result_d;
    end
  end

  // Valid is high for exactly one cycle per executing edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      result_valid_q <= `CALU_VALID_RST;
    end else begin
      result_valid_q <= exec_fire;
    end
  end

  // Read-back register, one cycle behind the read index
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= `CALU_WORD_RST;
    end else begin
      rd_data_q <= regs_q[host_rd_idx];
    end
  end

  // Outputs straight from their registers
  assign carry_flag = carry_q;
  assign result = result_q;
  assign result_valid = result_valid_q;
  assign host_rd_data = rd_data_q;

endmodule : calu_core

// >>> testbench/calu_core_assertions.sv
// Port checks for the carry-aware arithmetic and logic unit
`timescale 1ns/1ps
module calu_core_assertions (
  input wire logic clock,
  input wire logic rstn,
  input wire logic exec_en,
  input wire calu_pkg::calu_op_t exec_op,
  input wire logic exec_double,
  input wire logic carry_wr_en,
  input wire logic carry_flag,
  input wire logic [31:0] result,
  input wire logic result_valid
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Request classes
  wire logic go = exec_en && (exec_op <= 4'h9);
  wire logic arith = go && (exec_op <= 4'h3);
  wire logic keep_c = go && (exec_op >= 4'h4);
  sequence s_go_word;
    go && !exec_double;
  endsequence
  property p_valid; go |=> result_valid; endproperty
  a_valid: assert property (p_valid) else $error("valid missing");
  property p_refuse; !go |=> !result_valid && $stable(result); endproperty
  a_refuse: assert property (p_refuse) else $error("idle result moved");
  property p_word; s_go_word |=> result[31:16] == 16'h0000; endproperty
  a_word: assert property (p_word) else $error("word upper nonzero");
  property p_keepc; keep_c && !carry_wr_en |=> $stable(carry_flag); endproperty
  a_keepc: assert property (p_keepc) else $error("carry touched");
  property p_idlec; !exec_en && !carry_wr_en |=> $stable(carry_flag); endproperty
  a_idlec: assert property (p_idlec) else $error("carry drift");
  property p_crise; $changed(carry_flag) |-> $past(arith) || $past(carry_wr_en); endproperty
  a_crise: assert property (p_crise) else $error("carry cause");
  property p_back; go ##1 go |=> result_valid; endproperty
  a_back: assert property (p_back) else $error("back to back");
  property p_stop; go ##1 !exec_en |=> !result_valid; endproperty
  a_stop: assert property (p_stop) else $error("valid stuck");
endmodule : calu_core_assertions

// >>> testbench/calu_core_test.sv
// Self-checking bench for the carry-aware arithmetic and logic unit
`timescale 1ns/1ps
module calu_core_test;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic exec_en = 1'b0;
  logic exec_double = 1'b0;
  logic host_wr_en = 1'b0;
  logic carry_wr_en = 1'b0;
  logic carry_wr_data = 1'b0;
  logic [3:0] first_source = 4'h0, second_source = 4'h0, dest_idx = 4'h0;
  logic [3:0] host_wr_idx = 4'h0, host_rd_idx = 4'h0;
  logic [15:0] host_wr_data = 16'h0000, host_rd_data;
  calu_pkg::calu_op_t exec_op = calu_pkg::calu_op_adc;
  logic carry_flag, result_valid;
  logic [31:0] result;
  int err_total = 0, tests_run = 0, cyc = 0;
  calu_core i_calu_core (.clock(clock), .rstn(rstn), .exec_en(exec_en), .exec_op(exec_op),
    .exec_double(exec_double), .first_source(first_source), .second_source(second_source),
    .dest_idx(dest_idx), .host_wr_en(host_wr_en), .host_wr_idx(host_wr_idx),
    .host_wr_data(host_wr_data), .carry_wr_en(carry_wr_en), .carry_wr_data(carry_wr_data),
    .host_rd_idx(host_rd_idx), .host_rd_data(host_rd_data), .carry_flag(carry_flag),
    .result(result), .result_valid(result_valid));
  always #4 clock = ~clock;
  // Hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_flag(logic got, logic exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag
  task automatic chk_word(logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task automatic wr(logic [3:0] i, logic [15:0] d);
    @(posedge clock);
    host_wr_en <= 1'b1;
    host_wr_idx <= i;
    host_wr_data <= d;
    @(posedge clock);
    host_wr_en <= 1'b0;
  endtask : wr
  task automatic cset(logic c);
    @(posedge clock);
    carry_wr_en <= 1'b1;
    carry_wr_data <= c;
    @(posedge clock);
    carry_wr_en <= 1'b0;
  endtask : cset
  task automatic rd(logic [3:0] i, logic [15:0] e);
    @(posedge clock);
    host_rd_idx <= i;
    repeat (2) @(posedge clock);
    #1 chk_word(host_rd_data, e);
  endtask : rd
  // One execution, then result, carry and valid are judged
  task automatic run(calu_pkg::calu_op_t op, logic dbl, logic [3:0] a, logic [3:0] b,
    logic [3:0] d, logic [31:0] er, logic ec);
    @(posedge clock);
    exec_en <= 1'b1;
    exec_op <= op;
    exec_double <= dbl;
    first_source <= a;
    second_source <= b;
    dest_idx <= d;
    @(posedge clock);
    exec_en <= 1'b0;
    #1 chk(result, er);
    chk_flag(carry_flag, ec);
    chk_flag(result_valid, op <= 4'h9);
  endtask : run
  task automatic t_add();
    wr(4'h0, 16'h0011);
    wr(4'h1, 16'h0019);
    cset(1'b1);
    run(calu_pkg::calu_op_adc, 1'b0, 4'h0, 4'h1, 4'ha, 32'h0000002b, 1'b0);
    wr(4'h2, 16'hffff);
    wr(4'h3, 16'h0001);
    run(calu_pkg::calu_op_adc, 1'b0, 4'h2, 4'h3, 4'h4, 32'h00000000, 1'b1);
    wr(4'h4, 16'h0001);
    run(calu_pkg::calu_op_adc, 1'b1, 4'h2, 4'h4, 4'h6, 32'h00020001, 1'b0);
    rd(4'h7, 16'h0002);
  endtask : t_add
  task automatic t_sub();
    wr(4'h8, 16'h0010);
    wr(4'h9, 16'h0002);
    cset(1'b1);
    run(calu_pkg::calu_op_sub_borrow, 1'b0, 4'h8, 4'h9, 4'ha, 32'h0000000d, 1'b0);
    run(calu_pkg::calu_op_sub_borrow, 1'b0, 4'h9, 4'h8, 4'ha, 32'h0000fff2, 1'b1);
    wr(4'hb, 16'h0022);
    wr(4'hc, 16'h0013);
    run(calu_pkg::calu_op_bcd_sub_borrow, 1'b0, 4'hb, 4'hc, 4'hd, 32'h00000008, 1'b0);
    wr(4'he, 16'h0019);
    wr(4'hf, 16'h0028);
    run(calu_pkg::calu_op_bcd_adc, 1'b0, 4'he, 4'hf, 4'hd, 32'h00000047, 1'b0);
  endtask : t_sub
  task automatic t_unary();
    cset(1'b1);
    wr(4'h0, 16'h9a52);
    wr(4'h1, 16'h7a52);
    run(calu_pkg::calu_op_abs, 1'b0, 4'h0, 4'h0, 4'h0, 32'h000065ae, 1'b1);
    run(calu_pkg::calu_op_abs, 1'b0, 4'h0, 4'h0, 4'h1, 32'h00007a52, 1'b1);
    run(calu_pkg::calu_op_twos, 1'b0, 4'h0, 4'h0, 4'h1, 32'h000085ae, 1'b1);
    run(calu_pkg::calu_op_not, 1'b0, 4'h0, 4'h0, 4'h1, 32'h00007a51, 1'b1);
    rd(4'h1, 16'h7a51);
  endtask : t_unary
  task automatic t_logic();
    wr(4'h2, 16'h00ff);
    wr(4'h3, 16'h3333);
    run(calu_pkg::calu_op_and, 1'b0, 4'h2, 4'h3, 4'h4, 32'h00000033, 1'b1);
    run(calu_pkg::calu_op_or, 1'b0, 4'h2, 4'h3, 4'h4, 32'h000033ff, 1'b1);
    run(calu_pkg::calu_op_xor, 1'b0, 4'h2, 4'h3, 4'h4, 32'h000033cc, 1'b1);
    run(calu_pkg::calu_op_t'(4'hf), 1'b0, 4'h2, 4'h3, 4'h4, 32'h000033cc, 1'b1);
  endtask : t_logic
  // Request held high for three edges: each edge executes again
  task automatic t_burst();
    wr(4'h0, 16'h0001);
    cset(1'b0);
    @(posedge clock);
    exec_en <= 1'b1;
    exec_op <= calu_pkg::calu_op_adc;
    exec_double <= 1'b0;
    first_source <= 4'h0;
    second_source <= 4'h0;
    dest_idx <= 4'h0;
    repeat (2) @(posedge clock);
    #1 chk(result, 32'h00000004);
    chk_flag(result_valid, 1'b1);
    @(posedge clock);
    exec_en <= 1'b0;
    #1 chk(result, 32'h00000008);
    @(posedge clock);
    #1 chk_flag(result_valid, 1'b0);
    rd(4'h0, 16'h0008);
  endtask : t_burst
  // Double-word forms of every operation except the binary add, and the wrap of the high index
  task automatic t_double();
    cset(1'b0);
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0001);
    wr(4'h2, 16'h0001);
    wr(4'h3, 16'h0000);
    run(calu_pkg::calu_op_sub_borrow, 1'b1, 4'h0, 4'h2, 4'h4, 32'h0000ffff, 1'b0);
    run(calu_pkg::calu_op_sub_borrow, 1'b1, 4'h2, 4'h0, 4'h4, 32'hffff0001, 1'b1);
    wr(4'h6, 16'h9999);
    wr(4'h7, 16'h0999);
    wr(4'h8, 16'h0001);
    wr(4'h9, 16'h0000);
    run(calu_pkg::calu_op_bcd_adc, 1'b1, 4'h6, 4'h8, 4'ha, 32'h10000001, 1'b0);
    run(calu_pkg::calu_op_bcd_adc, 1'b0, 4'h6, 4'h8, 4'ha, 32'h00000000, 1'b1);
    run(calu_pkg::calu_op_bcd_sub_borrow, 1'b1, 4'h8, 4'h6, 4'ha, 32'h90000001, 1'b1);
    wr(4'hc, 16'hfffe);
    wr(4'hd, 16'hffff);
    run(calu_pkg::calu_op_abs, 1'b1, 4'h0, 4'h0, 4'hc, 32'h00000002, 1'b1);
    run(calu_pkg::calu_op_twos, 1'b1, 4'h0, 4'h0, 4'hc, 32'hfffffffe, 1'b1);
    run(calu_pkg::calu_op_not, 1'b1, 4'h0, 4'h0, 4'hc, 32'h00000001, 1'b1);
    rd(4'hd, 16'h0000);
    run(calu_pkg::calu_op_and, 1'b1, 4'h6, 4'h4, 4'he, 32'h09990001, 1'b1);
    run(calu_pkg::calu_op_or, 1'b1, 4'h6, 4'h4, 4'he, 32'hffff9999, 1'b1);
    run(calu_pkg::calu_op_xor, 1'b1, 4'h6, 4'h4, 4'hf, 32'hf6669998, 1'b1);
    rd(4'h0, 16'hf666);
  endtask : t_double
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    t_add();
    t_sub();
    t_unary();
    t_logic();
    t_burst();
    t_double();
    give_verdict();
  end
endmodule : calu_core_test
bind calu_core calu_core_assertions i_calu_core_assertions (.clock(clock), .rstn(rstn),
  .exec_en(exec_en), .exec_op(exec_op), .exec_double(exec_double),
  .carry_wr_en(carry_wr_en), .carry_flag(carry_flag), .result(result),
  .result_valid(result_valid));
